// ### spcu_pkg.sv
package spcu_pkg;
    // clock and line rates
    localparam int unsigned SPCU_CLK_HZ = 100_000_000;
    localparam int unsigned SPCU_BAUD_4800 = 4800;
    localparam int unsigned SPCU_BAUD_9600 = 9600;
    localparam int unsigned SPCU_BAUD_19200 = 19200;
    localparam int unsigned SPCU_BAUD_38400 = 38400;
    // cycles per bit, rounded down
    localparam logic [15:0] SPCU_DIV_4800 = 16'(SPCU_CLK_HZ / SPCU_BAUD_4800);
    localparam logic [15:0] SPCU_DIV_9600 = 16'(SPCU_CLK_HZ / SPCU_BAUD_9600);
    localparam logic [15:0] SPCU_DIV_19200 =
        16'(SPCU_CLK_HZ / SPCU_BAUD_19200);
    localparam logic [15:0] SPCU_DIV_38400 =
        16'(SPCU_CLK_HZ / SPCU_BAUD_38400);
    // character frame: start, eight data, no parity, one stop
    localparam int unsigned SPCU_DATA_BITS = 8;
    localparam int unsigned SPCU_STOP_BITS = 1;
    localparam int unsigned SPCU_FRAME_BITS =
        1 + SPCU_DATA_BITS + SPCU_STOP_BITS;
    localparam int unsigned SPCU_GAP_BITS = 2;
    localparam logic [2:0] SPCU_LAST_BIT = 3'(SPCU_DATA_BITS - 1);
    localparam logic [3:0] SPCU_PACE_BITS =
        4'(SPCU_FRAME_BITS + SPCU_GAP_BITS);
    // rates and serial states
    typedef enum logic [1:0] {
        SPCU_R4800 = 2'h0,
        SPCU_R9600 = 2'h1,
        SPCU_R19200 = 2'h2,
        SPCU_R38400 = 2'h3
    } spcu_rate_e;
    typedef enum logic [1:0] {
        SPCU_SER_IDLE = 2'h0,
        SPCU_SER_START = 2'h1,
        SPCU_SER_DATA = 2'h3,
        SPCU_SER_STOP = 2'h2
    } spcu_ser_e;
    localparam spcu_rate_e SPCU_HOST_RST_RATE = SPCU_R9600;
    localparam spcu_rate_e SPCU_AUX_RST_RATE = SPCU_R9600;
    // rate switch positions
    localparam int unsigned SPCU_SW_9K6 = 0;
    localparam int unsigned SPCU_SW_19K2 = 1;
    localparam int unsigned SPCU_SW_38K4 = 2;
    // unit identity
    localparam logic [3:0] SPCU_ID_MIN = 4'h1;
    localparam logic [3:0] SPCU_ID_MAX = 4'h9;
    localparam logic [3:0] SPCU_ID_DEFAULT = 4'h1;
    localparam logic [3:0] SPCU_BOOT_CYCLES = 4'h8;
    // register port
    typedef logic [3:0] spcu_addr_t;
    typedef logic [7:0] spcu_data_t;
    localparam spcu_addr_t SPCU_REG_CTRL = 4'h0;
    localparam spcu_addr_t SPCU_REG_STATUS = 4'h1;
    localparam spcu_addr_t SPCU_REG_AUX_RATE = 4'h2;
    localparam spcu_addr_t SPCU_REG_UNIT_ID = 4'h3;
    localparam spcu_addr_t SPCU_REG_HOST_DATA = 4'h4;
    localparam spcu_addr_t SPCU_REG_AUX_DATA = 4'h5;
    localparam spcu_addr_t SPCU_REG_PORT_STAT = 4'h6;
    localparam int unsigned SPCU_CTRL_LOAD = 0;
    localparam int unsigned SPCU_CTRL_IDRST = 1;
    localparam int unsigned SPCU_CTRL_CLRERR = 2;
    // ports and synchronised pin vector
    localparam int unsigned SPCU_PORTS = 2;
    localparam int unsigned SPCU_HOST = 0;
    localparam int unsigned SPCU_AUX = 1;
    localparam int unsigned SPCU_IN_W = 11;
    localparam int unsigned SPCU_IN_BAUD = 0;
    localparam int unsigned SPCU_IN_HMODE = 3;
    localparam int unsigned SPCU_IN_AJMP = 4;
    localparam int unsigned SPCU_IN_ID = 5;
    localparam int unsigned SPCU_IN_HRX = 9;
    localparam int unsigned SPCU_IN_ARX = 10;
    localparam logic [10:0] SPCU_IN_RST = 11'h600;
endpackage

// ### spcu_sync.sv
`timescale 1ns/1ps
module spcu_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins and filtered copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] m1;
        logic [W-1:0] m2;
        logic [W-1:0] m3;
        logic [W-1:0] q;
    } spcu_sync_s;

    spcu_sync_s st;
    spcu_sync_s nxt;
    logic [W-1:0] differ;

    // m1 feeds m2 only; a bit moves once m2 and m3 agree
    assign differ = st.m2 ^ st.m3;

    always_comb begin
        nxt = st;
        nxt.m1 = d;
        nxt.m2 = st.m1;
        nxt.m3 = st.m2;
        nxt.q = (st.m2 & ~differ) | (st.q & differ);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {RST, RST, RST, RST};
        end else begin
            st <= nxt;
        end
    end

    assign q = st.q;
endmodule

// ### spcu_pacer.sv
`timescale 1ns/1ps
module spcu_pacer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic en,
    input wire logic start,
    input wire logic [15:0] div,
    // hold-off toward the transmitter
    output logic hold
);
    import spcu_pkg::*;

    typedef struct packed {
        logic [15:0] cyc;
        logic [3:0] bits;
    } spcu_pace_s;

    spcu_pace_s st;
    spcu_pace_s nxt;

    // counts one frame plus idle bits from the moment a character is taken
    always_comb begin
        nxt = st;
        if (!en) begin
            nxt = '0;
        end else if (start) begin
            nxt.bits = SPCU_PACE_BITS;
            nxt.cyc = div - 16'h1;
        end else if (st.bits != '0) begin
            if (st.cyc != '0) begin
                nxt.cyc = st.cyc - 16'h1;
            end else begin
                nxt.cyc = div - 16'h1;
                nxt.bits = st.bits - 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign hold = st.bits != '0;
endmodule

// ### spcu_top.sv
// Overview of operation
// [RL1] Host rate switches pick 9600, 19200 or 38400 baud, 9600 default.
// [RL2] With every host rate switch off the host port runs at 4800 baud.
// [RL3] Rate switches are sampled once after power-up and then ignored.
// [RL4] Host characters use eight data bits, no parity and one stop bit.
// [RL5] Host line mode is RS-232 unless its selector says RS-485.
// [RL6] Auxiliary line mode is RS-485 unless the board jumper picks RS-232.
// [RL7] Auxiliary port starts at 9600 and changes only by the rate command.
// [RL8] Auxiliary characters use the same eight-none-one framing.
// [RL9] The host addresses up to nine units, each with a distinct identity.
// [RL10] Unit identity is 1 to 9 and falls back to 1.
// [RL11] Identity is captured at power-up and on a reset command, else held.
// [RL12] Hosts without a receive buffer must keep up or see overrun errors.
// [RL13] In program load mode host characters never go out back to back.
// [RL14] Each port's latched rate times both its transmitter and receiver.
`timescale 1ns/1ps
module spcu_top #(
    parameter logic [15:0] DIV_4800 = spcu_pkg::SPCU_DIV_4800,
    parameter logic [15:0] DIV_9600 = spcu_pkg::SPCU_DIV_9600,
    parameter logic [15:0] DIV_19200 = spcu_pkg::SPCU_DIV_19200,
    parameter logic [15:0] DIV_38400 = spcu_pkg::SPCU_DIV_38400
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // register port
    input wire spcu_pkg::spcu_addr_t REG_ADDR,
    input wire spcu_pkg::spcu_data_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output spcu_pkg::spcu_data_t REG_RDATA,
    // switches and jumpers
    input wire logic [2:0] HOST_BAUD_SW,
    input wire logic HOST_MODE_SW,
    input wire logic AUX_MODE_JMP,
    input wire logic [3:0] UNIT_ID_SW,
    // serial lines
    input wire logic HOST_RXD,
    output logic HOST_TXD,
    input wire logic AUX_RXD,
    output logic AUX_TXD,
    // configuration out
    output logic HOST_RS485,
    output logic AUX_RS485,
    output logic [3:0] UNIT_ID,
    output spcu_pkg::spcu_rate_e HOST_RATE,
    output spcu_pkg::spcu_rate_e AUX_RATE
);
    import spcu_pkg::*;

    typedef struct packed {
        logic [3:0] boot_cnt;
        logic boot_done;
        spcu_rate_e host_rate;
        spcu_rate_e aux_rate;
        logic [3:0] unit_id;
        logic host_485;
        logic aux_485;
        logic load_mode;
        logic [1:0][7:0] tx_buf;
        logic [1:0] tx_pend;
        spcu_ser_e [1:0] tx_st;
        logic [1:0][15:0] tx_cnt;
        logic [1:0][2:0] tx_bit;
        logic [1:0][7:0] tx_sh;
        logic [1:0] txd;
        spcu_ser_e [1:0] rx_st;
        logic [1:0][15:0] rx_cnt;
        logic [1:0][2:0] rx_bit;
        logic [1:0][7:0] rx_sh;
        logic [1:0][7:0] rx_buf;
        logic [1:0] rx_full;
        logic [1:0] ovr;
        logic [1:0] ferr;
        spcu_data_t rdata;
    } spcu_top_s;

    spcu_top_s st;
    spcu_top_s nxt;
    logic [SPCU_IN_W-1:0] pins;
    logic [SPCU_IN_W-1:0] in_q;
    logic [1:0][15:0] div;
    logic [1:0] rxd;
    logic [1:0] take;
    logic [1:0] wr_data;
    logic [1:0] rd_data;
    logic pace_hold;
    logic wr_ctrl;

    function automatic spcu_rate_e rate_of(input logic [2:0] sw);
        spcu_rate_e r;
        if (sw[SPCU_SW_9K6]) begin
            r = SPCU_R9600;
        end else if (sw[SPCU_SW_19K2]) begin
            r = SPCU_R19200;
        end else if (sw[SPCU_SW_38K4]) begin
            r = SPCU_R38400;
        end else begin
            r = SPCU_R4800; // [RL2]
        end
        return r; // [RL1]
    endfunction

    function automatic logic [15:0] div_of(input spcu_rate_e r);
        logic [15:0] d;
        unique case (r)
            SPCU_R4800: d = DIV_4800;
            SPCU_R9600: d = DIV_9600;
            SPCU_R19200: d = DIV_19200;
            SPCU_R38400: d = DIV_38400;
        endcase
        return d;
    endfunction

    // out-of-range selector positions fall back to the first unit
    function automatic logic [3:0] id_of(input logic [3:0] sw);
        logic [3:0] id;
        id = SPCU_ID_DEFAULT;
        if (sw >= SPCU_ID_MIN && sw <= SPCU_ID_MAX) begin
            id = sw;
        end
        return id; // [RL10]
    endfunction

    function automatic logic hit(input spcu_addr_t a);
        return REG_ADDR == a;
    endfunction

    assign pins = {AUX_RXD, HOST_RXD, UNIT_ID_SW, AUX_MODE_JMP,
                   HOST_MODE_SW, HOST_BAUD_SW};

    spcu_sync #(
        .W(SPCU_IN_W),
        .RST(SPCU_IN_RST)
    ) u_sync (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .d(pins),
        .q(in_q)
    );

    // one divisor per port serves both directions
    assign div[SPCU_HOST] = div_of(st.host_rate); // [RL14]
    assign div[SPCU_AUX] = div_of(st.aux_rate); // [RL14]
    assign rxd[SPCU_HOST] = in_q[SPCU_IN_HRX];
    assign rxd[SPCU_AUX] = in_q[SPCU_IN_ARX];
    assign wr_ctrl = REG_WR && hit(SPCU_REG_CTRL);
    assign wr_data[SPCU_HOST] = REG_WR && hit(SPCU_REG_HOST_DATA);
    assign wr_data[SPCU_AUX] = REG_WR && hit(SPCU_REG_AUX_DATA);
    assign rd_data[SPCU_HOST] = REG_RD && hit(SPCU_REG_HOST_DATA);
    assign rd_data[SPCU_AUX] = REG_RD && hit(SPCU_REG_AUX_DATA);

    // nothing leaves before the power-up rate is latched
    assign take[SPCU_HOST] = st.boot_done && st.tx_pend[SPCU_HOST] &&
        st.tx_st[SPCU_HOST] == SPCU_SER_IDLE && !pace_hold; // [RL13]
    assign take[SPCU_AUX] = st.boot_done && st.tx_pend[SPCU_AUX] &&
        st.tx_st[SPCU_AUX] == SPCU_SER_IDLE;

    spcu_pacer u_pacer (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .en(st.load_mode),
        .start(take[SPCU_HOST]),
        .div(div[SPCU_HOST]),
        .hold(pace_hold)
    );

    always_comb begin
        nxt = st;
        nxt.rdata = '0;
        nxt.host_485 = in_q[SPCU_IN_HMODE]; // [RL5]
        nxt.aux_485 = ~in_q[SPCU_IN_AJMP]; // [RL6]

        // power-up capture waits for the synchroniser to settle
        if (!st.boot_done) begin
            if (st.boot_cnt == SPCU_BOOT_CYCLES) begin
                nxt.boot_done = 1'h1;
                nxt.host_rate = rate_of(in_q[SPCU_IN_BAUD +: 3]); // [RL3]
                nxt.unit_id = id_of(in_q[SPCU_IN_ID +: 4]); // [RL11]
            end else begin
                nxt.boot_cnt = st.boot_cnt + 4'h1;
            end
        end

        if (wr_ctrl) begin
            nxt.load_mode = REG_WDATA[SPCU_CTRL_LOAD];
            if (REG_WDATA[SPCU_CTRL_IDRST]) begin
                nxt.unit_id = id_of(in_q[SPCU_IN_ID +: 4]); // [RL11]
            end
            if (REG_WDATA[SPCU_CTRL_CLRERR]) begin
                nxt.ovr = '0;
                nxt.ferr = '0;
            end
        end
        if (REG_WR && hit(SPCU_REG_AUX_RATE)) begin
            nxt.aux_rate = spcu_rate_e'(REG_WDATA[1:0]); // [RL7]
        end

        for (int i = 0; i < SPCU_PORTS; i++) begin
            // a full buffer ignores further writes
            if (wr_data[i] && !st.tx_pend[i]) begin
                nxt.tx_buf[i] = REG_WDATA;
                nxt.tx_pend[i] = 1'h1;
            end

            unique case (st.tx_st[i])
                SPCU_SER_IDLE: begin
                    nxt.txd[i] = 1'h1;
                    if (take[i]) begin
                        nxt.tx_sh[i] = st.tx_buf[i];
                        nxt.tx_pend[i] = 1'h0;
                        nxt.tx_cnt[i] = div[i] - 16'h1;
                        nxt.txd[i] = 1'h0;
                        nxt.tx_st[i] = SPCU_SER_START;
                    end
                end
                SPCU_SER_START: begin
                    if (st.tx_cnt[i] != '0) begin
                        nxt.tx_cnt[i] = st.tx_cnt[i] - 16'h1;
                    end else begin
                        nxt.txd[i] = st.tx_sh[i][0];
                        nxt.tx_bit[i] = '0;
                        nxt.tx_cnt[i] = div[i] - 16'h1;
                        nxt.tx_st[i] = SPCU_SER_DATA;
                    end
                end
                SPCU_SER_DATA: begin
                    if (st.tx_cnt[i] != '0) begin
                        nxt.tx_cnt[i] = st.tx_cnt[i] - 16'h1;
                    end else begin
                        nxt.tx_cnt[i] = div[i] - 16'h1;
                        // no parity bit: stop follows the eighth bit
                        if (st.tx_bit[i] == SPCU_LAST_BIT) begin
                            nxt.txd[i] = 1'h1; // [RL4] [RL8]
                            nxt.tx_st[i] = SPCU_SER_STOP;
                        end else begin
                            nxt.tx_sh[i] = st.tx_sh[i] >> 1;
                            nxt.txd[i] = st.tx_sh[i][1];
                            nxt.tx_bit[i] = st.tx_bit[i] + 3'h1;
                        end
                    end
                end
                SPCU_SER_STOP: begin
                    if (st.tx_cnt[i] != '0) begin
                        nxt.tx_cnt[i] = st.tx_cnt[i] - 16'h1;
                    end else begin
                        nxt.tx_st[i] = SPCU_SER_IDLE; // [RL4] [RL8]
                    end
                end
            endcase

            // a read frees the buffer; a new character in that cycle wins
            if (rd_data[i]) begin
                nxt.rx_full[i] = 1'h0;
            end

            unique case (st.rx_st[i])
                SPCU_SER_IDLE: begin
                    if (!rxd[i]) begin
                        nxt.rx_cnt[i] = div[i] >> 1;
                        nxt.rx_st[i] = SPCU_SER_START;
                    end
                end
                SPCU_SER_START: begin
                    if (st.rx_cnt[i] != '0) begin
                        nxt.rx_cnt[i] = st.rx_cnt[i] - 16'h1;
                    end else if (rxd[i]) begin
                        nxt.rx_st[i] = SPCU_SER_IDLE;
                    end else begin
                        nxt.rx_bit[i] = '0;
                        nxt.rx_cnt[i] = div[i] - 16'h1;
                        nxt.rx_st[i] = SPCU_SER_DATA;
                    end
                end
                SPCU_SER_DATA: begin
                    if (st.rx_cnt[i] != '0) begin
                        nxt.rx_cnt[i] = st.rx_cnt[i] - 16'h1;
                    end else begin
                        nxt.rx_sh[i] = {rxd[i], st.rx_sh[i][7:1]};
                        nxt.rx_cnt[i] = div[i] - 16'h1;
                        if (st.rx_bit[i] == SPCU_LAST_BIT) begin
                            nxt.rx_st[i] = SPCU_SER_STOP; // [RL4] [RL8]
                        end else begin
                            nxt.rx_bit[i] = st.rx_bit[i] + 3'h1;
                        end
                    end
                end
                SPCU_SER_STOP: begin
                    if (st.rx_cnt[i] != '0) begin
                        nxt.rx_cnt[i] = st.rx_cnt[i] - 16'h1;
                    end else begin
                        // unread data is overwritten; the flag records it
                        if (st.rx_full[i] && !rd_data[i]) begin
                            nxt.ovr[i] = 1'h1; // [RL12]
                        end
                        if (!rxd[i]) begin
                            nxt.ferr[i] = 1'h1; // [RL4] [RL8]
                        end
                        nxt.rx_buf[i] = st.rx_sh[i];
                        nxt.rx_full[i] = 1'h1;
                        nxt.rx_st[i] = SPCU_SER_IDLE;
                    end
                end
            endcase
        end

        // read data stand in the cycle after the strobe only
        if (REG_RD) begin
            unique case (REG_ADDR)
                SPCU_REG_CTRL: begin
                    nxt.rdata = {7'h00, st.load_mode};
                end
                SPCU_REG_STATUS: begin
                    nxt.rdata = {st.boot_done, st.load_mode, st.aux_485,
                                 st.host_485, st.aux_rate, st.host_rate};
                end
                SPCU_REG_AUX_RATE: begin
                    nxt.rdata = {6'h00, st.aux_rate};
                end
                SPCU_REG_UNIT_ID: begin
                    nxt.rdata = {4'h0, st.unit_id};
                end
                SPCU_REG_HOST_DATA: begin
                    nxt.rdata = st.rx_buf[SPCU_HOST];
                end
                SPCU_REG_AUX_DATA: begin
                    nxt.rdata = st.rx_buf[SPCU_AUX];
                end
                SPCU_REG_PORT_STAT: begin
                    nxt.rdata = {st.ferr[1], st.ovr[1], st.rx_full[1],
                                 st.tx_pend[1], st.ferr[0], st.ovr[0],
                                 st.rx_full[0], st.tx_pend[0]};
                end
                default: begin
                    nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st <= '0;
            st.txd <= '1;
            st.host_rate <= SPCU_HOST_RST_RATE;
            st.aux_rate <= SPCU_AUX_RST_RATE; // [RL7]
            st.unit_id <= SPCU_ID_DEFAULT; // [RL10]
            st.aux_485 <= 1'h1;
        end else begin
            st <= nxt;
        end
    end

    assign REG_RDATA = st.rdata;
    assign HOST_TXD = st.txd[SPCU_HOST];
    assign AUX_TXD = st.txd[SPCU_AUX];
    assign HOST_RS485 = st.host_485;
    assign AUX_RS485 = st.aux_485;
    assign UNIT_ID = st.unit_id;
    assign HOST_RATE = st.host_rate;
    assign AUX_RATE = st.aux_rate;
endmodule

// ### spcu_top_chk.sv
`timescale 1ns/1ps
module spcu_top_chk (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // register port
    input wire spcu_pkg::spcu_addr_t REG_ADDR,
    input wire spcu_pkg::spcu_data_t REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire spcu_pkg::spcu_data_t REG_RDATA,
    // selectors and configuration
    input wire logic HOST_MODE_SW,
    input wire logic AUX_MODE_JMP,
    input wire logic HOST_RS485,
    input wire logic AUX_RS485,
    input wire logic [3:0] UNIT_ID,
    input wire spcu_pkg::spcu_rate_e HOST_RATE,
    input wire spcu_pkg::spcu_rate_e AUX_RATE
);
    import spcu_pkg::*;
    logic [4:0] boot_ff;
    // saturates so the capture window is never seen again
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            boot_ff <= '0;
        end else if (boot_ff != 5'h1F) begin
            boot_ff <= boot_ff + 5'h01;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    AST_ID_RANGE: assert property (
        UNIT_ID >= SPCU_ID_MIN && UNIT_ID <= SPCU_ID_MAX)
        else $error("unit id out of range");
    AST_ID_EARLY: assert property (
        boot_ff < 5'h04 |-> UNIT_ID == SPCU_ID_DEFAULT)
        else $error("unit id not default before capture");
    AST_RATE_EARLY: assert property (
        boot_ff < 5'h04 |-> HOST_RATE == SPCU_HOST_RST_RATE)
        else $error("host rate not 9600 before capture");
    AST_RATE_HELD: assert property (
        boot_ff == 5'h1F |=> $stable(HOST_RATE))
        else $error("host rate moved after power-up");
    AST_AUX_SET: assert property (
        REG_WR && REG_ADDR == SPCU_REG_AUX_RATE
        |=> {6'h00, AUX_RATE} == ($past(REG_WDATA) & 8'h03))
        else $error("aux rate not taken from command");
    AST_AUX_HOLD: assert property (
        !(REG_WR && REG_ADDR == SPCU_REG_AUX_RATE) |=> $stable(AUX_RATE))
        else $error("aux rate moved without command");
    AST_ID_HELD: assert property (
        boot_ff == 5'h1F && !(REG_WR && REG_ADDR == SPCU_REG_CTRL
        && REG_WDATA[SPCU_CTRL_IDRST])
        |=> $stable(UNIT_ID))
        else $error("unit id moved without reset command");
    AST_ID_READ: assert property (
        REG_RD && REG_ADDR == SPCU_REG_UNIT_ID
        |=> REG_RDATA == {4'h0, $past(UNIT_ID)})
        else $error("unit id read back wrong");
    AST_HOST_MODE: assert property (
        $stable(HOST_MODE_SW) [*8] |-> HOST_RS485 == HOST_MODE_SW)
        else $error("host line mode wrong");
    AST_AUX_MODE: assert property (
        $stable(AUX_MODE_JMP) [*8] |-> AUX_RS485 == !AUX_MODE_JMP)
        else $error("aux line mode wrong");
endmodule
bind spcu_top spcu_top_chk u_chk (.CLOCK, .RESET_N, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .HOST_MODE_SW, .AUX_MODE_JMP,
    .HOST_RS485, .AUX_RS485, .UNIT_ID, .HOST_RATE, .AUX_RATE);

// ### spcu_ser_mdl.sv
`timescale 1ns/1ps
module spcu_ser_mdl (
    // clock
    input wire logic clk,
    // serial lines, bit time in cycles
    input wire logic txd,
    input wire logic [15:0] div,
    output logic rxd,
    // last character and its start cycle
    output logic [7:0] got,
    output int nfr,
    output int tst
);
    int cyc = 0;
    initial rxd = 1'b1;
    always @(posedge clk) cyc = cyc + 1;
    // mid-bit sampling; a low stop bit leaves the frame uncounted
    always begin
        @(negedge txd);
        tst = cyc;
        repeat (div / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk);
            got[i] = txd;
        end
        repeat (div) @(posedge clk);
        if (txd) nfr++;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rxd <= 1'b0;
        repeat (div) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rxd <= b[i];
            repeat (div) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (div) @(posedge clk);
    endtask
endmodule

// ### spcu_top_tb.sv
`timescale 1ns/1ps
module spcu_top_tb;
    import spcu_pkg::*;
    localparam logic [15:0] DV [4] = '{16'h0010, 16'h0008, 16'h0006,
        16'h0004};
    localparam logic [2:0] TB [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic hsw = 1'b0, ajmp = 1'b0, hrxd, arxd, htxd, atxd, h485, a485;
    logic [2:0] bsw = 3'h1;
    logic [3:0] isw = 4'h1, uid, k;
    logic [7:0] hgot, agot;
    logic [15:0] hdiv = 16'h0008, adiv = 16'h0008;
    spcu_addr_t addr = '0;
    spcu_data_t wdata = '0, rdata, d;
    spcu_rate_e hrate, arate;
    int hnfr, anfr, htst, atst, gap, failures = 0, checks = 0;
    always #5 clk = ~clk;
    spcu_top #(.DIV_4800(16'h0010), .DIV_9600(16'h0008),
        .DIV_19200(16'h0006), .DIV_38400(16'h0004)) u_spcu_top (
        .CLOCK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .HOST_BAUD_SW(bsw),
        .HOST_MODE_SW(hsw), .AUX_MODE_JMP(ajmp), .UNIT_ID_SW(isw),
        .HOST_RXD(hrxd), .HOST_TXD(htxd), .AUX_RXD(arxd), .AUX_TXD(atxd),
        .HOST_RS485(h485), .AUX_RS485(a485), .UNIT_ID(uid),
        .HOST_RATE(hrate), .AUX_RATE(arate));
    spcu_ser_mdl u_host (.clk(clk), .txd(htxd), .div(hdiv), .rxd(hrxd),
        .got(hgot), .nfr(hnfr), .tst(htst));
    spcu_ser_mdl u_aux (.clk(clk), .txd(atxd), .div(adiv), .rxd(arxd),
        .got(agot), .nfr(anfr), .tst(atst));
    function automatic logic [1:0] exp_rate(input logic [2:0] s);
        return s[0] ? 2'h1 : s[1] ? 2'h2 : s[2] ? 2'h3 : 2'h0;
    endfunction
    function automatic logic [3:0] exp_id(input logic [3:0] s);
        return (s >= 4'h1 && s <= 4'h9) ? s : 4'h1;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input spcu_addr_t a, input spcu_data_t v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input spcu_addr_t a, output spcu_data_t v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic reboot();
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
    endtask
    // one character out, then its inverse back in on port p
    task automatic xfer(input int p, input logic [7:0] b);
        int n;
        spcu_addr_t a;
        a = p ? SPCU_REG_AUX_DATA : SPCU_REG_HOST_DATA;
        n = p ? anfr : hnfr;
        wr_reg(a, b);
        for (int i = 0; i < 400 && (p ? anfr : hnfr) == n; i++)
            @(posedge clk);
        chk(p ? agot : hgot, b);
        chk(8'((p ? anfr : hnfr) - n), 8'h01);
        if (p) u_aux.send(~b);
        else u_host.send(~b);
        repeat (8) @(posedge clk);
        rd_reg(a, d);
        chk(d, ~b);
    endtask
    // two host characters queued back to back; start-to-start gap
    task automatic pace(input logic [7:0] ld);
        int n, t1;
        n = hnfr;
        wr_reg(SPCU_REG_CTRL, ld);
        wr_reg(SPCU_REG_HOST_DATA, 8'($urandom));
        wr_reg(SPCU_REG_HOST_DATA, 8'($urandom));
        for (int i = 0; i < 600 && hnfr < n + 1; i++) @(posedge clk);
        t1 = htst;
        for (int i = 0; i < 600 && hnfr < n + 2; i++) @(posedge clk);
        gap = htst - t1;
        chk(8'(gap >= 12 * hdiv), 8'(ld[0]));
        chk(8'(hnfr - n), 8'h02);
    endtask
    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #300_000;
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(78051));
        repeat (8) @(posedge clk);
        chk(8'(uid), 8'h01);
        chk(8'(arate), 8'h01);
        chk(8'(a485), 8'h01);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        foreach (TB[i]) begin
            bsw <= TB[i];
            isw <= 4'($urandom % 16);
            hsw <= i[0];
            ajmp <= i[1];
            reboot();
            hdiv = DV[exp_rate(TB[i])];
            chk(8'(hrate), 8'(exp_rate(TB[i])));
            chk(8'(uid), 8'(exp_id(isw)));
            chk(8'(h485), 8'(hsw));
            chk(8'(a485), 8'(!ajmp));
            rd_reg(SPCU_REG_STATUS, d);
            chk(d, {2'h2, !ajmp, hsw, 2'h1, exp_rate(TB[i])});
            xfer(0, 8'($urandom));
            bsw <= ~TB[i];
            repeat (12) @(posedge clk);
            chk(8'(hrate), 8'(exp_rate(TB[i])));
            $display("rate case %0d done", i);
        end
        k = uid;
        isw <= 4'($urandom % 9) + 4'h1;
        repeat (12) @(posedge clk);
        chk(8'(uid), 8'(k));
        wr_reg(SPCU_REG_CTRL, 8'h02);
        repeat (2) @(posedge clk);
        chk(8'(uid), 8'(isw));
        rd_reg(SPCU_REG_UNIT_ID, d);
        chk(d, 8'(isw));
        rd_reg(4'h9, d);
        chk(d, 8'h00);
        $display("unit id test done");
        for (int c = 0; c < 4; c++) begin
            wr_reg(SPCU_REG_AUX_RATE, 8'(c));
            adiv = DV[c];
            @(negedge clk);
            chk(8'(arate), 8'(c));
            xfer(1, 8'($urandom));
        end
        $display("aux rate test done");
        pace(8'h01);
        pace(8'h00);
        $display("pacing test done");
        stop_test();
    end
endmodule
